// [design/pfc_pkg.sv]
package pfc_pkg;

    // Clock and switching timing
    localparam int          CLK_HZ         = 25_000_000;
    localparam int          CLK_PERIOD_NS  = 40;
    localparam int          SWITCH_HZ      = 100_000;
    localparam int          MIN_OFF_NS     = 400;
    localparam int          MAX_DUTY_PCT   = 95;
    localparam logic [7:0]  PERIOD_CYC     = 8'(CLK_HZ / SWITCH_HZ);
    localparam logic [7:0]  MIN_OFF_CYC    = 8'((MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0]  MAX_ON_CYC     = 8'((CLK_HZ / SWITCH_HZ) * MAX_DUTY_PCT / 100);

    // Register byte offsets
    localparam logic [3:0]  CTRL_OFS       = 4'h0;
    localparam logic [3:0]  STATUS_OFS     = 4'h4;
    localparam logic [3:0]  CYCLE_OFS      = 4'h8;

    // Control field positions and reset values
    localparam int          CTRL_RUN_BIT   = 0;
    localparam int          SOFT_TRIM_LSB  = 8;
    localparam int          WIN_TRIM_LSB   = 16;
    localparam logic        RUN_RST        = 1'b1;
    localparam logic [7:0]  SOFT_TRIM_RST  = 8'h14;
    localparam logic [7:0]  WIN_TRIM_RST   = 8'h0a;

    // Cycle register field positions
    localparam int          CYC_CNT_LSB    = 0;
    localparam int          CYC_LAST_LSB   = 8;

    // Comparator results entering the block
    typedef struct packed {
        logic supply_lockout;
        logic input_brownout_guard;
        logic open_loop_guard;
        logic peak_current_limit;
        logic overvoltage_guard;
        logic overvoltage_soft;
        logic window_high;
        logic window_low;
        logic ramp_crossing_comparator;
    } sense_t;

    localparam int          SENSE_W        = $bits(sense_t);

    // Latch and mode state reported in status
    typedef struct packed {
        logic on_latch;
        logic limit_latch;
        logic gate;
        logic ramp_discharge;
        logic standby;
    } pwm_state_t;

    typedef enum logic [0:0] {
        ST_STANDBY = 1'b0,
        ST_RUN     = 1'b1
    } run_state_t;

endpackage

// [design/bit_sync.sv]
`timescale 1ns/1ps

module bit_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] stage1;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end

endmodule

// [design/pfc_pwm_gate_logic.sv]
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps

module pfc_pwm_gate_logic #(
    parameter logic [7:0] PERIOD  = pfc_pkg::PERIOD_CYC,
    parameter logic [7:0] MIN_OFF = pfc_pkg::MIN_OFF_CYC,
    parameter logic [7:0] MAX_ON  = pfc_pkg::MAX_ON_CYC
) (
    // Clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    // Comparator inputs
    input  wire pfc_pkg::sense_t sense_in,
    // Avalon-MM slave
    input  wire logic [3:0]      avs_address,
    input  wire logic            avs_read,
    input  wire logic            avs_write,
    input  wire logic [31:0]     avs_writedata,
    input  wire logic [3:0]      avs_byteenable,
    output logic      [31:0]     avs_readdata,
    output logic                 avs_waitrequest,
    // Gate driver and analog controls
    output logic                 gate_drive,
    output logic                 ramp_discharge,
    output logic                 standby_mode
);

    if (PERIOD < 8'h04 || MIN_OFF == 8'h00 || MAX_ON == 8'h00 || {1'b0, MIN_OFF} + {1'b0, MAX_ON} > {1'b0, PERIOD})
    begin : g_param_check
        $error("pfc_pwm_gate_logic: cycle counts cannot be served");
    end

    // Synchronised comparator results
    pfc_pkg::sense_t          sense_s;
    logic [pfc_pkg::SENSE_W-1:0] sense_q;

    bit_sync #(
        .W       (pfc_pkg::SENSE_W)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .d       (sense_in),
        .q       (sense_q)
    );

    assign sense_s = pfc_pkg::sense_t'(sense_q);

    // Control register
    logic                     run_enable;
    logic [7:0]               soft_trim;
    logic [7:0]               win_trim;

    // Cycle timing
    logic [7:0]               cnt;
    logic [7:0]               on_cnt;
    logic [7:0]               last_on;
    logic                     on_latch;
    logic                     limit_latch;
    pfc_pkg::run_state_t      run_state;

    wire                      cycle_wrap    = (cnt == PERIOD - 8'h01);
    wire  [7:0]               next_cnt      = cycle_wrap ? 8'h00 : cnt + 8'h01;
    wire                      next_min_off  = (next_cnt < MIN_OFF);

    // Fault and standby
    wire                      fault         = sense_s.supply_lockout | sense_s.input_brownout_guard
                                              | sense_s.open_loop_guard;
    pfc_pkg::run_state_t      next_state;

    always_comb begin
        next_state = run_state;
        unique case (run_state)
            pfc_pkg::ST_STANDBY: begin
                if (!fault && cycle_wrap) begin
                    next_state = pfc_pkg::ST_RUN;
                end
            end
            pfc_pkg::ST_RUN: begin
                if (fault) begin
                    next_state = pfc_pkg::ST_STANDBY;
                end
            end
        endcase
    end

    wire                      next_run      = (next_state == pfc_pkg::ST_RUN);

    // End of allowed on window, shortened by soft overvoltage and window high
    wire  [8:0]               max_end       = {1'b0, MIN_OFF} + {1'b0, MAX_ON};
    wire  [8:0]               soft_cut      = sense_s.overvoltage_soft ? {1'b0, soft_trim} : 9'h000;
    wire  [8:0]               win_cut       = sense_s.window_high ? {1'b0, win_trim} : 9'h000;
    wire  [9:0]               cut_sum       = {1'b0, soft_cut} + {1'b0, win_cut};
    wire                      cut_floor     = ({1'b0, max_end} <= cut_sum + {2'b00, MIN_OFF});
    wire  [8:0]               end_cnt       = cut_floor ? {1'b0, MIN_OFF} : 9'(max_end - cut_sum[8:0]);

    // Latches: minimum off pulse wins over every set
    wire                      set_on        = sense_s.ramp_crossing_comparator | sense_s.window_low;
    wire                      next_on_latch = next_min_off ? 1'b0 : (on_latch | set_on);
    wire                      next_limit    = next_min_off ? 1'b0 : (limit_latch | sense_s.peak_current_limit);

    wire                      allow_next    = run_enable & next_run & ~fault & ~next_min_off
                                              & ({1'b0, next_cnt} < end_cnt)
                                              & ~sense_s.overvoltage_guard & ~sense_s.supply_lockout;
    wire                      next_gate     = allow_next & next_on_latch & ~next_limit;
    wire                      next_ramp_dis = next_min_off | ~next_run;

    wire  [7:0]               next_on_cnt   = cycle_wrap ? 8'h00 : (gate_drive ? on_cnt + 8'h01 : on_cnt);
    wire  [7:0]               on_total      = gate_drive ? on_cnt + 8'h01 : on_cnt;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt            <= 8'h00;
            run_state      <= pfc_pkg::ST_STANDBY;
            on_latch       <= 1'b0;
            limit_latch    <= 1'b0;
            gate_drive     <= 1'b0;
            ramp_discharge <= 1'b1;
            standby_mode   <= 1'b1;
            on_cnt         <= 8'h00;
            last_on        <= 8'h00;
        end else begin
            cnt            <= next_cnt;
            run_state      <= next_state;
            on_latch       <= next_on_latch;
            limit_latch    <= next_limit;
            gate_drive     <= next_gate;
            ramp_discharge <= next_ramp_dis;
            standby_mode   <= ~next_run;
            on_cnt         <= next_on_cnt;
            if (cycle_wrap) begin
                last_on    <= on_total;
            end
        end
    end

    // Avalon-MM slave, one wait state on every access
    wire                      bus_req       = avs_read | avs_write;
    wire                      bus_take      = bus_req & avs_waitrequest;
    wire                      bus_done      = bus_req & ~avs_waitrequest;
    wire                      sel_ctrl      = (avs_address == pfc_pkg::CTRL_OFS);
    wire                      sel_status    = (avs_address == pfc_pkg::STATUS_OFS);
    wire                      sel_cycle     = (avs_address == pfc_pkg::CYCLE_OFS);
    wire                      ctrl_wr       = bus_done & avs_write & sel_ctrl;

    pfc_pkg::pwm_state_t      pwm_state;

    assign pwm_state = '{on_latch:       on_latch,
                         limit_latch:    limit_latch,
                         gate:           gate_drive,
                         ramp_discharge: ramp_discharge,
                         standby:        standby_mode};

    wire  [31:0]              ctrl_word     = {8'h00, win_trim, soft_trim, 7'h00, run_enable};
    wire  [31:0]              status_word   = {18'h00000, sense_s, pwm_state};
    wire  [31:0]              cycle_word    = {16'h0000, last_on, cnt};
    wire  [31:0]              rd_mux        = sel_ctrl   ? ctrl_word
                                            : sel_status ? status_word
                                            : sel_cycle  ? cycle_word
                                            : 32'h00000000;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            avs_waitrequest <= ~bus_take;
            if (bus_take && avs_read) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            run_enable <= pfc_pkg::RUN_RST;
            soft_trim  <= pfc_pkg::SOFT_TRIM_RST;
            win_trim   <= pfc_pkg::WIN_TRIM_RST;
        end else if (ctrl_wr) begin
            if (avs_byteenable[0]) begin
                run_enable <= avs_writedata[pfc_pkg::CTRL_RUN_BIT];
            end
            if (avs_byteenable[1]) begin
                soft_trim  <= avs_writedata[pfc_pkg::SOFT_TRIM_LSB +: 8];
            end
            if (avs_byteenable[2]) begin
                win_trim   <= avs_writedata[pfc_pkg::WIN_TRIM_LSB +: 8];
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    property p_period;
        (cnt == 8'h00) |-> ##250 (cnt == 8'h00);
    endproperty
    a_period: assert property (p_period) else $error("cycle period not 250 clocks");

    property p_min_off_low;
        (cnt < MIN_OFF) |-> (!gate_drive && ramp_discharge);
    endproperty
    a_min_off_low: assert property (p_min_off_low) else $error("gate high or ramp released in min off");

    property p_ramp_release;
        (cnt == MIN_OFF && !standby_mode) |-> !ramp_discharge ##1 (!ramp_discharge || standby_mode);
    endproperty
    a_ramp_release: assert property (p_ramp_release) else $error("ramp not released after min off");

    property p_trip_on;
        (sense_s.ramp_crossing_comparator && allow_next && !next_limit) |=> (gate_drive && on_latch);
    endproperty
    a_trip_on: assert property (p_trip_on) else $error("ramp crossing did not turn gate on");

    property p_limit_hold;
        (limit_latch && !next_min_off) |=> limit_latch;
    endproperty
    a_limit_hold: assert property (p_limit_hold) else $error("limit latch released before cycle end");

    property p_limit_low;
        (sense_s.peak_current_limit && !next_min_off) |=> limit_latch && !gate_drive;
    endproperty
    a_limit_low: assert property (p_limit_low) else $error("peak limit did not force gate low");

    property p_limit_cycle;
        limit_latch |-> !gate_drive;
    endproperty
    a_limit_cycle: assert property (p_limit_cycle) else $error("gate high while limit latched");

    property p_latch_clear;
        (cnt < MIN_OFF) |-> (!on_latch && !limit_latch);
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("latches not cleared in min off");

    property p_max_duty;
        on_cnt <= MAX_ON;
    endproperty
    a_max_duty: assert property (p_max_duty) else $error("gate high time above 95 percent");

    property p_soft_ov;
        (sense_s.overvoltage_soft && !sense_s.window_high && soft_trim != 8'h00
         && {1'b0, next_cnt} >= max_end - {1'b0, soft_trim}) |=> !gate_drive;
    endproperty
    a_soft_ov: assert property (p_soft_ov) else $error("soft overvoltage did not shorten duty");

    property p_hard_ov;
        sense_s.overvoltage_guard |=> !gate_drive;
    endproperty
    a_hard_ov: assert property (p_hard_ov) else $error("hard overvoltage left gate on");

    property p_window_low;
        (sense_s.window_low && allow_next && !next_limit) |=> gate_drive;
    endproperty
    a_window_low: assert property (p_window_low) else $error("window low did not raise duty");

    property p_active_high;
        gate_drive |-> (on_latch && !limit_latch && !standby_mode && $past(run_enable));
    endproperty
    a_active_high: assert property (p_active_high) else $error("gate high without on condition");

    property p_lockout;
        sense_s.supply_lockout |=> (!gate_drive && standby_mode);
    endproperty
    a_lockout: assert property (p_lockout) else $error("gate not held low in lockout");

    property p_fault_standby;
        fault |=> (standby_mode && ramp_discharge && !gate_drive);
    endproperty
    a_fault_standby: assert property (p_fault_standby) else $error("fault did not enter standby");

    property p_sync;
        ##2 (sense_s == $past(sense_in, 2));
    endproperty
    a_sync: assert property (p_sync) else $error("comparator inputs not two-stage synchronised");

    c_gate_on: cover property (!gate_drive ##1 gate_drive);
    c_limit: cover property (gate_drive ##1 limit_latch);
    c_hard_ov: cover property (gate_drive && sense_s.overvoltage_guard);
    c_wake: cover property (standby_mode ##1 !standby_mode);

endmodule

// [tb/switch_model.sv]
`timescale 1ns/1ps

module switch_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Gate from the block
    input  wire logic       gate_drive,
    // Bench controls
    input  wire logic       limit_en,
    input  wire logic [7:0] limit_after,
    // Current over limit
    output logic            peak_current_limit
);
    logic [7:0] on_time;

    // Current builds while switch conducts, clears to zero when off
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            on_time <= 8'h00;
        end else if (gate_drive) begin
            on_time <= on_time + 8'h01;
        end else begin
            on_time <= 8'h00;
        end
    end

    assign peak_current_limit = limit_en && (on_time >= limit_after);
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps

module tb_top;
    logic            clk_sys = 1'b0;
    logic            rst_n = 1'b0;
    pfc_pkg::sense_t sense_tb = '0;
    pfc_pkg::sense_t sense_in;
    logic [3:0]      avs_address = 4'h0;
    logic            avs_read = 1'b0;
    logic            avs_write = 1'b0;
    logic [31:0]     avs_writedata = 32'h0;
    logic [3:0]      avs_byteenable = 4'hf;
    logic [31:0]     avs_readdata;
    logic            avs_waitrequest;
    logic            gate_drive;
    logic            ramp_discharge;
    logic            standby_mode;
    logic            limit_en = 1'b0;
    logic [7:0]      limit_after = 8'h1e;
    logic            peak_current_limit;
    logic [31:0]     rd;
    int              err_total = 0;
    int              tests_run = 0;
    int              cyc = 0;
    int              per;
    int              off;
    int              on;
    int              on0;

    always #20 clk_sys = ~clk_sys;

    always_comb begin
        sense_in = sense_tb;
        sense_in.peak_current_limit = peak_current_limit;
    end

    pfc_pwm_gate_logic uut (.clk_sys(clk_sys), .rst_n(rst_n), .sense_in(sense_in), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .gate_drive(gate_drive), .ramp_discharge(ramp_discharge), .standby_mode(standby_mode));

    switch_model sw (.clk_sys(clk_sys), .rst_n(rst_n), .gate_drive(gate_drive), .limit_en(limit_en),
        .limit_after(limit_after), .peak_current_limit(peak_current_limit));

    task automatic test_done;
        $display("errors %0d comparisons %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_int(input integer got, input integer exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask

    // Bus cycles, entered just after a rising edge
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask

    // One full switching cycle, start to start
    task automatic watch_cycle;
        int n;
        int both;
        logic last;
        n = 0;
        both = 0;
        while (ramp_discharge !== 1'b0 && n < 600) begin
            @(posedge clk_sys);
            n++;
        end
        while (ramp_discharge !== 1'b1 && n < 600) begin
            @(posedge clk_sys);
            n++;
        end
        per = 0;
        off = 0;
        on = 0;
        last = 1'b1;
        while (!(ramp_discharge === 1'b1 && last === 1'b0) && per < 600) begin
            last = ramp_discharge;
            per++;
            if (ramp_discharge === 1'b1) off++;
            if (gate_drive === 1'b1) on++;
            if (gate_drive !== 1'b0 && ramp_discharge !== 1'b0) both++;
            @(posedge clk_sys);
        end
        chk_int(both, 0);
    endtask

    task automatic wait_run;
        int n;
        n = 0;
        while (standby_mode !== 1'b0 && n < 800) begin
            @(posedge clk_sys);
            n++;
        end
        chk_bit(standby_mode, 1'b0);
    endtask

    task automatic t_reset;
        chk_bit(gate_drive, 1'b0);
        chk_bit(standby_mode, 1'b1);
        chk_bit(ramp_discharge, 1'b1);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        bus_wr(4'hc, 32'hffffffff, 4'hf);
        bus_rd(pfc_pkg::CTRL_OFS, rd);
        chk_word(rd, 32'h000a1401);
        bus_rd(4'hc, rd);
        chk_word(rd, 32'h0);
    endtask

    task automatic t_cycle;
        sense_tb.ramp_crossing_comparator <= 1'b1;
        wait_run;
        watch_cycle;
        chk_int(per, 250);
        chk_int(off, 10);
        chk_bit(on <= 237 && on >= 234, 1'b1);
        on0 = on;
        bus_rd(pfc_pkg::CYCLE_OFS, rd);
        chk_int({24'h000000, rd[15:8]}, on0);
        sense_tb.ramp_crossing_comparator <= 1'b0;
        watch_cycle;
        chk_int(on, 0);
    endtask

    task automatic t_limits;
        sense_tb.ramp_crossing_comparator <= 1'b1;
        limit_en <= 1'b1;
        watch_cycle;
        chk_bit(on >= 30 && on <= 34, 1'b1);
        limit_en <= 1'b0;
        sense_tb.overvoltage_guard <= 1'b1;
        watch_cycle;
        chk_int(on, 0);
        sense_tb.overvoltage_guard <= 1'b0;
        bus_wr(pfc_pkg::CTRL_OFS, 32'hffff0500, 4'h2);
        bus_rd(pfc_pkg::CTRL_OFS, rd);
        chk_word(rd, 32'h000a0501);
        sense_tb.overvoltage_soft <= 1'b1;
        watch_cycle;
        chk_int(on, on0 - 5);
        sense_tb.overvoltage_soft <= 1'b0;
        sense_tb.window_high <= 1'b1;
        watch_cycle;
        chk_int(on, on0 - 10);
        sense_tb.window_high <= 1'b0;
        sense_tb.ramp_crossing_comparator <= 1'b0;
        sense_tb.window_low <= 1'b1;
        watch_cycle;
        chk_int(on, on0);
    endtask

    task automatic t_run_off;
        bus_wr(pfc_pkg::CTRL_OFS, 32'h000a0500, 4'hf);
        watch_cycle;
        chk_int(on, 0);
        bus_wr(pfc_pkg::CTRL_OFS, 32'h000a0501, 4'hf);
        watch_cycle;
        chk_int(on, on0);
    endtask

    task automatic t_faults;
        int hi;
        for (int i = 6; i <= 8; i++) begin
            sense_tb[i] <= 1'b1;
            repeat (5) @(posedge clk_sys);
            chk_bit(standby_mode, 1'b1);
            bus_rd(pfc_pkg::STATUS_OFS, rd);
            chk_word(rd & ((32'h00000001 << (i + 5)) | 32'h00000007), (32'h00000001 << (i + 5)) | 32'h00000003);
            hi = 0;
            repeat (260) begin
                @(posedge clk_sys);
                if (gate_drive !== 1'b0) hi++;
            end
            chk_int(hi, 0);
            sense_tb[i] <= 1'b0;
            wait_run;
        end
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            $display("BAD %0t timeout", $time);
            test_done;
        end
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        t_reset;
        t_cycle;
        t_limits;
        t_run_off;
        t_faults;
        test_done;
    end
endmodule
